// *** core/nvsc_top.sv ***
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module nvsc_top #(
	parameter int ADDR_W = nvsc_pkg::REG_ADDR_W
) (
	// Clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// Register port
	input  wire logic [ADDR_W-1:0]           regAddr,
	input  wire logic [7:0]                  regWdata,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic      [7:0]                  regRdata,
	// Array side
	output logic                             nvmStart,
	output nvsc_pkg::nvsc_op_type            nvmOp,
	output logic      [nvsc_pkg::NVM_ADDR_W-1:0] nvmAddr,
	output logic      [nvsc_pkg::WORD_W-1:0] nvmWdata,
	output logic                             nvmProgSpace,
	output logic                             nvmCfgSpace,
	input  wire logic [nvsc_pkg::WORD_W-1:0] nvmRdata,
	input  wire logic                        nvmDone,
	// Interrupt
	output logic                             irq
);
	logic [7:0]                       addrLow;
	logic [nvsc_pkg::ADDR_HIGH_W-1:0] addrHigh;
	logic [7:0]                       dataLow;
	logic [nvsc_pkg::DATA_HIGH_W-1:0] dataHigh;

	logic programSpaceSelect;
	logic configSpaceSelect;
	logic latchOnlyLoad;
	logic eraseSelect;
	logic writeErrorFlag;
	logic programEnable;
	logic writeStart;
	logic readStart;

	logic                       busy;
	nvsc_pkg::nvsc_op_type      curOp;
	nvsc_pkg::nvsc_op_type      next_op;
	logic [nvsc_pkg::IRQ_W-1:0] irqStatus;
	logic [nvsc_pkg::IRQ_W-1:0] irqMask;
	logic [nvsc_pkg::IRQ_W-1:0] irqSet;

	logic ctlWr;
	logic wrReq;
	logic rdReq;
	logic launch;
	logic refused;
	logic opDone;
	logic arraySpace;
	logic [7:0] ctlByte;

	nvsc_key_if keyBus ();

	assign ctlWr   = regWr && (regAddr == nvsc_pkg::OFS_CONTROL);
	// Setting an already set start bit is not a new request
	assign wrReq   = ctlWr && regWdata[nvsc_pkg::CTL_WRITE_START] && !writeStart && !busy;
	assign rdReq   = ctlWr && regWdata[nvsc_pkg::CTL_READ_START] && !readStart && !busy && !wrReq;
	assign launch  = wrReq && keyBus.armed && programEnable;
	assign refused = wrReq && !launch;
	assign opDone  = busy && nvmDone;
	assign arraySpace = programSpaceSelect || configSpaceSelect;

	assign keyBus.keyWr   = regWr && (regAddr == nvsc_pkg::OFS_KEY);
	assign keyBus.keyData = regWdata;
	assign keyBus.consume = wrReq;
	assign keyBus.otherWr = regWr && !keyBus.keyWr && !(ctlWr && regWdata[nvsc_pkg::CTL_WRITE_START]);

	nvsc_unlock u_unlock (
		.mclk   (mclk),
		.rst    (rst),
		.keyBus (keyBus.seq)
	);

	// Kind of cycle the next start performs
	always_comb begin
		if (eraseSelect && arraySpace) begin
			next_op = nvsc_pkg::OP_ERASE;
		end else if (latchOnlyLoad && arraySpace) begin
			next_op = nvsc_pkg::OP_LATCH;
		end else begin
			next_op = nvsc_pkg::OP_WRITE;
		end
	end

	// Selection bits frozen while a cycle runs so the array sees stable targets
	always_ff @(posedge mclk) begin
		if (rst) begin
			programSpaceSelect <= 1'b0;
			configSpaceSelect  <= 1'b0;
			latchOnlyLoad      <= 1'b0;
			programEnable      <= 1'b0;
		end else if (ctlWr && !busy) begin
			programSpaceSelect <= regWdata[nvsc_pkg::CTL_PROG_SPACE];
			configSpaceSelect  <= regWdata[nvsc_pkg::CTL_CFG_SPACE];
			latchOnlyLoad      <= regWdata[nvsc_pkg::CTL_LATCH_ONLY];
			programEnable      <= regWdata[nvsc_pkg::CTL_PROG_ENABLE];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			eraseSelect <= 1'b0;
		end else if (opDone && curOp == nvsc_pkg::OP_ERASE) begin
			eraseSelect <= 1'b0;
		end else if (ctlWr && !busy) begin
			eraseSelect <= regWdata[nvsc_pkg::CTL_ERASE_SEL];
		end
	end

	// A refused start attempt sets the error flag; the set wins over a clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			writeErrorFlag <= 1'b0;
		end else if (refused) begin
			writeErrorFlag <= 1'b1;
		end else if (ctlWr) begin
			writeErrorFlag <= regWdata[nvsc_pkg::CTL_WRITE_ERR];
		end
	end

	// Start bits are set-only from software and cleared on completion
	always_ff @(posedge mclk) begin
		if (rst) begin
			writeStart <= 1'b0;
			readStart  <= 1'b0;
		end else if (opDone) begin
			writeStart <= 1'b0;
			readStart  <= 1'b0;
		end else if (launch) begin
			writeStart <= 1'b1;
		end else if (rdReq) begin
			readStart <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			busy     <= 1'b0;
			curOp    <= nvsc_pkg::OP_NONE;
			nvmStart <= 1'b0;
			nvmOp    <= nvsc_pkg::OP_NONE;
		end else begin
			nvmStart <= launch || rdReq;
			if (opDone) begin
				busy  <= 1'b0;
				curOp <= nvsc_pkg::OP_NONE;
			end else if (launch) begin
				busy  <= 1'b1;
				curOp <= next_op;
				nvmOp <= next_op;
			end else if (rdReq) begin
				busy  <= 1'b1;
				curOp <= nvsc_pkg::OP_READ;
				nvmOp <= nvsc_pkg::OP_READ;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			addrLow  <= nvsc_pkg::BYTE_ZERO;
			addrHigh <= nvsc_pkg::BYTE_ZERO[nvsc_pkg::ADDR_HIGH_W-1:0];
		end else if (regWr && !busy) begin
			if (regAddr == nvsc_pkg::OFS_ADDR_LOW) begin
				addrLow <= regWdata;
			end
			if (regAddr == nvsc_pkg::OFS_ADDR_HIGH) begin
				addrHigh <= regWdata[nvsc_pkg::ADDR_HIGH_W-1:0];
			end
		end
	end

	// Read completion overrides software so the fetched word is never lost
	always_ff @(posedge mclk) begin
		if (rst) begin
			dataLow  <= nvsc_pkg::BYTE_ZERO;
			dataHigh <= nvsc_pkg::BYTE_ZERO[nvsc_pkg::DATA_HIGH_W-1:0];
		end else if (opDone && curOp == nvsc_pkg::OP_READ) begin
			dataLow  <= nvmRdata[nvsc_pkg::BYTE_W-1:0];
			dataHigh <= nvmRdata[nvsc_pkg::WORD_W-1:nvsc_pkg::BYTE_W];
		end else if (regWr && !busy) begin
			if (regAddr == nvsc_pkg::OFS_DATA_LOW) begin
				dataLow <= regWdata;
			end
			if (regAddr == nvsc_pkg::OFS_DATA_HIGH) begin
				dataHigh <= regWdata[nvsc_pkg::DATA_HIGH_W-1:0];
			end
		end
	end

	assign nvmAddr      = {addrHigh, addrLow};
	assign nvmWdata     = {dataHigh, dataLow};
	assign nvmProgSpace = programSpaceSelect;
	assign nvmCfgSpace  = configSpaceSelect;

	// Interrupt status: hardware set wins over write-one-to-clear
	always_comb begin
		irqSet = '0;
		irqSet[nvsc_pkg::IRQ_DONE]    = opDone && curOp != nvsc_pkg::OP_READ;
		irqSet[nvsc_pkg::IRQ_REFUSED] = refused;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irqStatus <= '0;
			irqMask   <= '0;
		end else begin
			if (regWr && regAddr == nvsc_pkg::OFS_IRQ_STATUS) begin
				irqStatus <= (irqStatus & ~regWdata[nvsc_pkg::IRQ_W-1:0]) | irqSet;
			end else begin
				irqStatus <= irqStatus | irqSet;
			end
			if (regWr && regAddr == nvsc_pkg::OFS_IRQ_MASK) begin
				irqMask <= regWdata[nvsc_pkg::IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irqStatus & irqMask);

	always_comb begin
		ctlByte = '0;
		ctlByte[nvsc_pkg::CTL_PROG_SPACE]  = programSpaceSelect;
		ctlByte[nvsc_pkg::CTL_CFG_SPACE]   = configSpaceSelect;
		ctlByte[nvsc_pkg::CTL_LATCH_ONLY]  = latchOnlyLoad;
		ctlByte[nvsc_pkg::CTL_ERASE_SEL]   = eraseSelect;
		ctlByte[nvsc_pkg::CTL_WRITE_ERR]   = writeErrorFlag;
		ctlByte[nvsc_pkg::CTL_PROG_ENABLE] = programEnable;
		ctlByte[nvsc_pkg::CTL_WRITE_START] = writeStart;
		ctlByte[nvsc_pkg::CTL_READ_START]  = readStart;
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdata <= nvsc_pkg::BYTE_ZERO;
		end else if (regRd) begin
			unique case (regAddr)
				nvsc_pkg::OFS_CONTROL:    regRdata <= ctlByte;
				nvsc_pkg::OFS_KEY:        regRdata <= nvsc_pkg::BYTE_ZERO;
				nvsc_pkg::OFS_ADDR_LOW:   regRdata <= addrLow;
				nvsc_pkg::OFS_ADDR_HIGH:  regRdata <= {nvsc_pkg::ADDR_HIGH_PAD, addrHigh};
				nvsc_pkg::OFS_DATA_LOW:   regRdata <= dataLow;
				nvsc_pkg::OFS_DATA_HIGH:  regRdata <= {nvsc_pkg::DATA_HIGH_PAD, dataHigh};
				nvsc_pkg::OFS_IRQ_STATUS: regRdata <= {{(8-nvsc_pkg::IRQ_W){1'b0}}, irqStatus};
				nvsc_pkg::OFS_IRQ_MASK:   regRdata <= {{(8-nvsc_pkg::IRQ_W){1'b0}}, irqMask};
				default:                  regRdata <= nvsc_pkg::BYTE_ZERO;
			endcase
		end else begin
			regRdata <= nvsc_pkg::BYTE_ZERO;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	chk_launch_needs_unlock: assert property (
		nvmStart && nvmOp != nvsc_pkg::OP_READ |-> $past(keyBus.armed && ctlWr))
		else $error("Program cycle launched without unlock");

	chk_launch_needs_enable: assert property (
		nvmStart && nvmOp != nvsc_pkg::OP_READ |-> $past(programEnable) && writeStart)
		else $error("Program cycle launched without enable");

	chk_start_held: assert property (
		writeStart && !nvmDone |=> writeStart)
		else $error("Write start dropped before completion");

	chk_erase_kind: assert property (
		nvmStart && nvmOp == nvsc_pkg::OP_ERASE |-> $past(eraseSelect && arraySpace))
		else $error("Erase launched without erase select");

	chk_write_kind: assert property (
		launch && !eraseSelect && !latchOnlyLoad |=> nvmStart && nvmOp == nvsc_pkg::OP_WRITE)
		else $error("Write launch produced wrong operation");

	chk_erase_clears: assert property (
		opDone && curOp == nvsc_pkg::OP_ERASE |=> !eraseSelect && !writeStart)
		else $error("Erase select not cleared after erase");

	chk_key_reads_zero: assert property (
		regRd && regAddr == nvsc_pkg::OFS_KEY |=> regRdata == nvsc_pkg::BYTE_ZERO)
		else $error("Unlock key register returned data");

	chk_addr_top_one: assert property (
		regRd && regAddr == nvsc_pkg::OFS_ADDR_HIGH |=> regRdata[7] && regRdata[6:0] == $past(addrHigh))
		else $error("High address readback wrong");

	chk_data_high_pad: assert property (
		regRd && regAddr == nvsc_pkg::OFS_DATA_HIGH |=> regRdata[7:6] == nvsc_pkg::DATA_HIGH_PAD)
		else $error("High data top bits not zero");

	chk_refused_flags: assert property (
		refused |=> writeErrorFlag && irqStatus[nvsc_pkg::IRQ_REFUSED] && !busy)
		else $error("Refused start not flagged");

	cov_erase_cycle: cover property (launch && next_op == nvsc_pkg::OP_ERASE ##[1:100] opDone);
	cov_write_cycle: cover property (launch && next_op == nvsc_pkg::OP_WRITE ##[1:100] opDone);
	cov_read_cycle:  cover property (rdReq ##[1:100] opDone);
	cov_refused:     cover property (refused);
endmodule : nvsc_top

// *** shared/nvsc_pkg.sv ***
// Functional notes
// - Write-start launches nothing unless a valid unlock sequence came just before.
// - Unlock key register stores nothing readable; writes only feed the sequence check.
// - Erase-select with config or program space makes the next start erase, else latch-only with a space selected latches, else write.
// - Hardware clears erase-select once the erase cycle it started has finished.
// - Top bit of the high address register reads one; writes to it are ignored.
// - High address register holds seven writable upper address bits.
// - High data register holds six bits of the 14-bit word; top two read zero.
package nvsc_pkg;
	localparam int REG_ADDR_W = 3;
	localparam int BYTE_W = 8;
	localparam int NVM_ADDR_W = 15;
	localparam int WORD_W = 14;
	localparam int ADDR_HIGH_W = 7;
	localparam int DATA_HIGH_W = 6;
	localparam int IRQ_W = 2;

	localparam logic [REG_ADDR_W-1:0] OFS_CONTROL    = 3'h0;
	localparam logic [REG_ADDR_W-1:0] OFS_KEY        = 3'h1;
	localparam logic [REG_ADDR_W-1:0] OFS_ADDR_LOW   = 3'h2;
	localparam logic [REG_ADDR_W-1:0] OFS_ADDR_HIGH  = 3'h3;
	localparam logic [REG_ADDR_W-1:0] OFS_DATA_LOW   = 3'h4;
	localparam logic [REG_ADDR_W-1:0] OFS_DATA_HIGH  = 3'h5;
	localparam logic [REG_ADDR_W-1:0] OFS_IRQ_STATUS = 3'h6;
	localparam logic [REG_ADDR_W-1:0] OFS_IRQ_MASK   = 3'h7;

	localparam int CTL_PROG_SPACE  = 7;
	localparam int CTL_CFG_SPACE   = 6;
	localparam int CTL_LATCH_ONLY  = 5;
	localparam int CTL_ERASE_SEL   = 4;
	localparam int CTL_WRITE_ERR   = 3;
	localparam int CTL_PROG_ENABLE = 2;
	localparam int CTL_WRITE_START = 1;
	localparam int CTL_READ_START  = 0;

	localparam int IRQ_DONE    = 0;
	localparam int IRQ_REFUSED = 1;

	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic       ADDR_HIGH_PAD = 1'h1;
	localparam logic [1:0] DATA_HIGH_PAD = 2'h0;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_READ,
		OP_WRITE,
		OP_ERASE,
		OP_LATCH
	} nvsc_op_type;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_ARMED
	} nvsc_key_type;
endpackage : nvsc_pkg

// *** shared/nvsc_key_if.sv ***
`timescale 1ns/1ps
interface nvsc_key_if;
	logic       keyWr;
	logic [7:0] keyData;
	logic       otherWr;
	logic       consume;
	logic       armed;

	modport ctrl (output keyWr, output keyData, output otherWr, output consume, input armed);
	modport seq  (input keyWr, input keyData, input otherWr, input consume, output armed);
endinterface : nvsc_key_if

// *** core/nvsc_unlock.sv ***
`timescale 1ns/1ps
module nvsc_unlock (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Key traffic from the register side
	nvsc_key_if.seq  keyBus
);
	nvsc_pkg::nvsc_key_type keyState;

	// Any unrelated write breaks the sequence, so the launch must follow directly
	always_ff @(posedge mclk) begin
		if (rst) begin
			keyState <= nvsc_pkg::KEY_IDLE;
		end else if (keyBus.consume || keyBus.otherWr) begin
			keyState <= nvsc_pkg::KEY_IDLE;
		end else if (keyBus.keyWr) begin
			unique case (keyState)
				nvsc_pkg::KEY_GOT_FIRST: begin
					if (keyBus.keyData == nvsc_pkg::KEY_SECOND) begin
						keyState <= nvsc_pkg::KEY_ARMED;
					end else if (keyBus.keyData == nvsc_pkg::KEY_FIRST) begin
						keyState <= nvsc_pkg::KEY_GOT_FIRST;
					end else begin
						keyState <= nvsc_pkg::KEY_IDLE;
					end
				end
				default: begin
					if (keyBus.keyData == nvsc_pkg::KEY_FIRST) begin
						keyState <= nvsc_pkg::KEY_GOT_FIRST;
					end else begin
						keyState <= nvsc_pkg::KEY_IDLE;
					end
				end
			endcase
		end
	end

	assign keyBus.armed = (keyState == nvsc_pkg::KEY_ARMED);

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	chk_arm_after_pair: assert property (
		$rose(keyBus.armed) |-> $past(keyBus.keyWr && keyBus.keyData == nvsc_pkg::KEY_SECOND))
		else $error("Armed without second key byte");

	chk_arm_consumed: assert property (
		keyBus.consume |=> !keyBus.armed)
		else $error("Unlock not consumed by launch attempt");

	chk_arm_broken: assert property (
		keyBus.otherWr |=> !keyBus.armed)
		else $error("Unlock survived an unrelated write");
endmodule : nvsc_unlock

// *** verif/nvsc_top_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin nCompared++; if ((got) !== (exp)) begin nMismatch++; $display("unexpected at %0t: %s", $time, msg); end end
module nvsc_top_tb_top;
	logic                      mclk = 1'b0;
	logic                      rst = 1'b1;
	logic [2:0]                regAddr = 3'h0;
	logic [7:0]                regWdata = 8'h00;
	logic                      regWr = 1'b0;
	logic                      regRd = 1'b0;
	logic [7:0]                regRdata;
	logic                      nvmStart;
	nvsc_pkg::nvsc_op_type     nvmOp;
	logic [14:0]               nvmAddr;
	logic [13:0]               nvmWdata;
	logic                      nvmProgSpace;
	logic                      nvmCfgSpace;
	logic [13:0]               nvmRdata = 14'h0000;
	logic                      nvmDone = 1'b0;
	logic                      irq;
	int                        nMismatch = 0;
	int                        nCompared = 0;

	always #25 mclk = ~mclk;

	nvsc_top u_nvsc_top (
		.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .nvmStart(nvmStart), .nvmOp(nvmOp), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata),
		.nvmProgSpace(nvmProgSpace), .nvmCfgSpace(nvmCfgSpace), .nvmRdata(nvmRdata), .nvmDone(nvmDone), .irq(irq)
	);

	// Strobe is left high so writes can run back to back
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		regRd <= 1'b0;
	endtask : wr

	task idle();
		@(posedge mclk);
		regWr <= 1'b0;
		regRd <= 1'b0;
	endtask : idle

	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		d = regRdata;
	endtask : rd

	task unlock();
		wr(nvsc_pkg::OFS_KEY, nvsc_pkg::KEY_FIRST);
		wr(nvsc_pkg::OFS_KEY, nvsc_pkg::KEY_SECOND);
	endtask : unlock

	// Counts start pulses in a short window; latency is not pinned to one cycle
	task launch(input logic [7:0] ctl, output int cnt, output nvsc_pkg::nvsc_op_type op);
		wr(nvsc_pkg::OFS_CONTROL, ctl);
		idle();
		cnt = 0;
		op = nvsc_pkg::OP_NONE;
		repeat (4) begin
			@(negedge mclk);
			if (nvmStart === 1'b1) begin
				cnt++;
				op = nvmOp;
			end
		end
	endtask : launch

	task pulse_done(input logic [13:0] w);
		@(posedge mclk);
		nvmRdata <= w;
		nvmDone <= 1'b1;
		@(posedge mclk);
		nvmDone <= 1'b0;
	endtask : pulse_done

	task check_reset();
		logic [7:0] d;
		logic [7:0] rstVal [8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], d);
			`CHK(d, rstVal[i], "reset value")
		end
		`CHK(irq, 1'b0, "irq after reset")
	endtask : check_reset

	task check_fields();
		logic [7:0] d;
		wr(nvsc_pkg::OFS_ADDR_HIGH, 8'hff);
		wr(nvsc_pkg::OFS_ADDR_LOW, 8'h11);
		wr(nvsc_pkg::OFS_DATA_HIGH, 8'hff);
		wr(nvsc_pkg::OFS_DATA_LOW, 8'h22);
		wr(nvsc_pkg::OFS_KEY, 8'h55);
		rd(nvsc_pkg::OFS_ADDR_HIGH, d);
		`CHK(d, 8'hff, "address high")
		rd(nvsc_pkg::OFS_DATA_HIGH, d);
		`CHK(d, 8'h3f, "data high")
		rd(nvsc_pkg::OFS_KEY, d);
		`CHK(d, 8'h00, "key readback")
		`CHK(nvmAddr, 15'h7f11, "array address")
		`CHK(nvmWdata, 14'h3f22, "array word")
	endtask : check_fields

	task check_ops();
		logic [7:0] d;
		int cnt;
		nvsc_pkg::nvsc_op_type op;
		logic [7:0] ctl [4] = '{8'h04, 8'h94, 8'ha4, 8'h54};
		nvsc_pkg::nvsc_op_type ops [4] = '{nvsc_pkg::OP_WRITE, nvsc_pkg::OP_ERASE, nvsc_pkg::OP_LATCH,
			nvsc_pkg::OP_ERASE};
		wr(nvsc_pkg::OFS_IRQ_MASK, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(nvsc_pkg::OFS_CONTROL, ctl[i]);
			unlock();
			launch(ctl[i] | 8'h02, cnt, op);
			`CHK(cnt, 1, "start count")
			`CHK(op, ops[i], "operation kind")
			`CHK({nvmProgSpace, nvmCfgSpace}, ctl[i][7:6], "space selects")
			wr(nvsc_pkg::OFS_ADDR_LOW, 8'h5a);
			rd(nvsc_pkg::OFS_CONTROL, d);
			`CHK(d & 8'h02, 8'h02, "start held while busy")
			pulse_done(14'h0000);
			rd(nvsc_pkg::OFS_CONTROL, d);
			`CHK(d, ctl[i] & 8'he4, "control after done")
			rd(nvsc_pkg::OFS_ADDR_LOW, d);
			`CHK(d, 8'h11, "busy write ignored")
			`CHK(irq, 1'b1, "done irq")
			wr(nvsc_pkg::OFS_IRQ_STATUS, 8'h01);
			idle();
			@(negedge mclk);
			`CHK(irq, 1'b0, "done irq cleared")
		end
	endtask : check_ops

	task check_read();
		logic [7:0] d;
		int cnt;
		nvsc_pkg::nvsc_op_type op;
		launch(8'h01, cnt, op);
		`CHK(op, nvsc_pkg::OP_READ, "read kind")
		pulse_done(14'h2abc);
		rd(nvsc_pkg::OFS_DATA_HIGH, d);
		`CHK(d, 8'h2a, "read word high")
		rd(nvsc_pkg::OFS_DATA_LOW, d);
		`CHK(d, 8'hbc, "read word low")
	endtask : check_read

	task try_refused(input logic [7:0] k1, input logic [7:0] k2, input logic between, input logic [7:0] ctl);
		logic [7:0] d;
		int cnt;
		nvsc_pkg::nvsc_op_type op;
		// Enable is taken from the stored control byte, so set it (and clear the error flag) first
		wr(nvsc_pkg::OFS_CONTROL, ctl & 8'hfd);
		wr(nvsc_pkg::OFS_KEY, k1);
		wr(nvsc_pkg::OFS_KEY, k2);
		if (between) begin
			wr(nvsc_pkg::OFS_ADDR_LOW, 8'h11);
		end
		launch(ctl, cnt, op);
		`CHK(cnt, 0, "refused start launched")
		rd(nvsc_pkg::OFS_CONTROL, d);
		`CHK(d & 8'h0a, 8'h08, "refusal flags")
		rd(nvsc_pkg::OFS_IRQ_STATUS, d);
		`CHK(d, 8'h02, "refusal status")
	endtask : try_refused

	task check_refusals();
		wr(nvsc_pkg::OFS_IRQ_MASK, 8'h01);
		try_refused(8'h00, 8'h00, 1'b0, 8'h06);
		`CHK(irq, 1'b0, "masked refusal irq")
		wr(nvsc_pkg::OFS_IRQ_MASK, 8'h03);
		idle();
		@(negedge mclk);
		`CHK(irq, 1'b1, "unmasked refusal irq")
		wr(nvsc_pkg::OFS_IRQ_STATUS, 8'h02);
		try_refused(8'haa, 8'h55, 1'b0, 8'h06);
		wr(nvsc_pkg::OFS_IRQ_STATUS, 8'h02);
		try_refused(8'h55, 8'haa, 1'b1, 8'h06);
		wr(nvsc_pkg::OFS_IRQ_STATUS, 8'h02);
		try_refused(8'h55, 8'haa, 1'b0, 8'h02);
		wr(nvsc_pkg::OFS_IRQ_STATUS, 8'h02);
		idle();
		@(negedge mclk);
		`CHK(irq, 1'b0, "refusal irq cleared")
	endtask : check_refusals

	task finish_test();
		$display("mismatches %0d compared %0d", nMismatch, nCompared);
		if (nMismatch == 0 && nCompared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		check_reset();
		check_fields();
		check_ops();
		check_read();
		check_refusals();
		finish_test();
	end

	// Whole run is under two hundred cycles; this only catches a stuck handshake
	initial begin
		repeat (5000) @(posedge mclk);
		nMismatch++;
		finish_test();
	end
endmodule : nvsc_top_tb_top
